// file: include/nsps_map.vh
// register map, field positions, reset values and timing counts of the nap/sleep sequencer
// assumes byte addressing on a 32-bit apb with one aligned word per register
`ifndef NSPS_MAP_VH
`define NSPS_MAP_VH

// =====================================================================
// register offsets
`define NSPS_OFS_HWCFG 12'h000
`define NSPS_OFS_MSR 12'h004
`define NSPS_OFS_L2CTL 12'h008
`define NSPS_OFS_STATUS 12'h00C

// =====================================================================
// hardware configuration register fields
`define NSPS_HW_DOZE 8
`define NSPS_HW_NAP 9
`define NSPS_HW_SLEEP 10
`define NSPS_HW_MASK 32'h00000700

// =====================================================================
// machine state register fields
`define NSPS_MSR_POW 0
`define NSPS_MSR_EE 1
`define NSPS_MSR_MASK 32'h00000003

// =====================================================================
// l2 control register fields
`define NSPS_L2_ENABLE 0
`define NSPS_L2_SRAM_SLEEP 1
`define NSPS_L2_MASK 32'h00000003

// =====================================================================
// status register fields
`define NSPS_ST_STATE_LSB 0
`define NSPS_ST_QUIESCE_REQUEST 4
`define NSPS_ST_SNOOP 5
`define NSPS_ST_CAUSE_LSB 8
`define NSPS_ST_BUSCNT_LSB 16

// =====================================================================
// reset values
`define NSPS_RST_HWCFG 32'h00000000
`define NSPS_RST_MSR 32'h00000000
`define NSPS_RST_L2CTL 32'h00000000

// =====================================================================
// timing counts in processor clocks or bus clocks
`define NSPS_ENTRY_CYCLES 4
`define NSPS_WAKE_CYCLES 2
`define NSPS_SNOOP_BUS_CLOCKS 8

`endif

// file: logic/nsps_sync3.v
// three-stage synchroniser bank with agreement filter, one lane per bit
// assumes inputs asynchronous to pclk; output changes once stages two and three agree
`timescale 1ns/100ps
module nsps_sync3 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // asynchronous inputs
    input wire [WIDTH-1:0] async_in,
    // filtered synchronous outputs
    output wire [WIDTH-1:0] sync_out
);

// =====================================================================
// per-bit synchroniser
genvar gi;
generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_lane
        reg s1_r;
        reg s2_r;
        reg s3_r;
        reg out_r;
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                s1_r <= RESET_VAL[gi];
                s2_r <= RESET_VAL[gi];
                s3_r <= RESET_VAL[gi];
                out_r <= RESET_VAL[gi];
            end
            else
            begin
                s1_r <= async_in[gi];
                s2_r <= s1_r;
                s3_r <= s2_r;
                if (s2_r == s3_r)
                begin
                    out_r <= s3_r;
                end
            end
        end
        assign sync_out[gi] = out_r;
    end
endgenerate

endmodule

// file: logic/nsps_seq.v
// nap and sleep power sequencer with apb register access
// assumes bus_clk_en is a one-cycle pulse per bus clock and bus_idle comes from pclk logic
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "nsps_map.vh"
module nsps_seq (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // system handshake pins
    input wire quiesce_acknowledge_n,
    output reg quiesce_request_n,
    // wake sources
    input wire ext_interrupt_n,
    input wire system_mgmt_interrupt_in_n,
    input wire machine_check_in_n,
    input wire soft_reset_n,
    input wire machine_check_event,
    input wire decrementer_event,
    // bus status and timing from pclk logic
    input wire bus_idle,
    input wire bus_clk_en,
    // pll configuration pin
    input wire pll_bypass,
    // power domain controls
    output reg units_clk_en,
    output reg snoop_en,
    output reg timebase_en,
    output reg thermal_en,
    output reg receivers_en,
    output reg sram_sleep_out,
    output reg pll_run,
    output reg dll_en,
    output reg l2_clock_out_a_en,
    output reg l2_clock_out_b_en
);

// =====================================================================
// states
localparam ST_FULL = 4'h0;
localparam ST_BUSWAIT = 4'h1;
localparam ST_QUIESCE_REQUEST = 4'h2;
localparam ST_ENTER = 4'h3;
localparam ST_NAP = 4'h4;
localparam ST_NAPSNOOP = 4'h5;
localparam ST_SLEEP = 4'h6;
localparam ST_WAKE = 4'h7;

localparam [3:0] ENTRY_CNT = `NSPS_ENTRY_CYCLES;
localparam [3:0] WAKE_CNT = `NSPS_WAKE_CYCLES;
localparam [3:0] SNOOP_CNT = `NSPS_SNOOP_BUS_CLOCKS;
localparam [31:0] RST_HW = `NSPS_RST_HWCFG;
localparam [31:0] RST_MSR = `NSPS_RST_MSR;
localparam [31:0] RST_L2 = `NSPS_RST_L2CTL;

// wake cause codes
localparam [2:0] CAUSE_NONE = 3'h0;
localparam [2:0] CAUSE_EXT = 3'h1;
localparam [2:0] CAUSE_SMI = 3'h2;
localparam [2:0] CAUSE_MCP = 3'h3;
localparam [2:0] CAUSE_MCHK = 3'h4;
localparam [2:0] CAUSE_DEC = 3'h5;
localparam [2:0] CAUSE_SRST = 3'h6;

// =====================================================================
// pin synchronisers
wire [5:0] pins_sync;
nsps_sync3 #(
    .WIDTH(6),
    .RESET_VAL(6'h1F)
) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({pll_bypass, soft_reset_n, machine_check_in_n, system_mgmt_interrupt_in_n,
        ext_interrupt_n, quiesce_acknowledge_n}),
    .sync_out(pins_sync)
);

wire quiesce_acknowledge = ~pins_sync[0];
wire ext_int = ~pins_sync[1];
wire system_mgmt_interrupt_in = ~pins_sync[2];
wire machine_check_in = ~pins_sync[3];
wire soft_rst = ~pins_sync[4];
wire bypass = pins_sync[5];

// =====================================================================
// registers
reg [2:0] hwcfg_r;
reg pow_r;
reg ee_r;
reg l2e_r;
reg sram_ctl_r;
reg [3:0] state_r;
reg [3:0] state_nxt;
reg [3:0] cnt_r;
reg [3:0] cnt_nxt;
reg [3:0] bus_cnt_r;
reg [3:0] bus_cnt_nxt;
reg [2:0] cause_r;
reg [2:0] cause_nxt;
reg sleep_sel_r;
reg sleep_sel_nxt;

wire wr_en = psel & penable & pwrite;
wire addr_ok = (paddr == `NSPS_OFS_HWCFG) | (paddr == `NSPS_OFS_MSR) |
    (paddr == `NSPS_OFS_L2CTL) | (paddr == `NSPS_OFS_STATUS);

assign pready = 1'b1;
assign pslverr = psel & penable & ~addr_ok;

// mode selection: exactly one of the three bits, nap or sleep
wire sel_nap = (hwcfg_r == 3'b010);
wire sel_sleep = (hwcfg_r == 3'b100);
wire invoke = pow_r & ee_r & (sel_nap | sel_sleep);

// wake sources differ between nap and sleep
wire wake_nap = (ext_int & ee_r) | system_mgmt_interrupt_in | machine_check_in | machine_check_event | decrementer_event;
wire wake_sleep = (ext_int & ee_r) | system_mgmt_interrupt_in | machine_check_in;
wire in_low = (state_r == ST_NAP) | (state_r == ST_NAPSNOOP) | (state_r == ST_SLEEP);
wire wake_now = soft_rst | (((state_r == ST_SLEEP) ? wake_sleep : wake_nap) & in_low);

// =====================================================================
// sequencer
always @*
begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    bus_cnt_nxt = bus_cnt_r;
    cause_nxt = cause_r;
    sleep_sel_nxt = sleep_sel_r;
    case (state_r)
        ST_FULL:
        begin
            if (invoke)
            begin
                sleep_sel_nxt = sel_sleep;
                state_nxt = ST_BUSWAIT;
            end
        end
        ST_BUSWAIT:
        begin
            if (bus_idle)
            begin
                state_nxt = ST_QUIESCE_REQUEST;
            end
        end
        ST_QUIESCE_REQUEST:
        begin
            if (quiesce_acknowledge)
            begin
                cnt_nxt = ENTRY_CNT;
                state_nxt = ST_ENTER;
            end
        end
        ST_ENTER:
        begin
            if (cnt_r <= 4'h1)
            begin
                bus_cnt_nxt = 4'h0;
                state_nxt = sleep_sel_r ? ST_SLEEP : ST_NAP;
            end
            else
            begin
                cnt_nxt = cnt_r - 4'h1;
            end
        end
        ST_NAP:
        begin
            if (quiesce_acknowledge)
            begin
                bus_cnt_nxt = 4'h0;
            end
            else if (bus_clk_en)
            begin
                if (bus_cnt_r >= SNOOP_CNT - 4'h1)
                begin
                    state_nxt = ST_NAPSNOOP;
                end
                else
                begin
                    bus_cnt_nxt = bus_cnt_r + 4'h1;
                end
            end
        end
        ST_NAPSNOOP:
        begin
            if (quiesce_acknowledge)
            begin
                bus_cnt_nxt = 4'h0;
                state_nxt = ST_NAP;
            end
        end
        ST_SLEEP:
        begin
            state_nxt = ST_SLEEP;
        end
        ST_WAKE:
        begin
            if (cnt_r <= 4'h1)
            begin
                state_nxt = ST_FULL;
            end
            else
            begin
                cnt_nxt = cnt_r - 4'h1;
            end
        end
        default:
        begin
            state_nxt = ST_FULL;
        end
    endcase
    // wake from entered low-power states, or from any state on soft reset; quiesce wait holds until acknowledge
    if (wake_now)
    begin
        cnt_nxt = WAKE_CNT;
        state_nxt = ST_WAKE;
        if (soft_rst)
            cause_nxt = CAUSE_SRST;
        else if (ext_int & ee_r)
            cause_nxt = CAUSE_EXT;
        else if (system_mgmt_interrupt_in)
            cause_nxt = CAUSE_SMI;
        else if (machine_check_in)
            cause_nxt = CAUSE_MCP;
        else if (machine_check_event)
            cause_nxt = CAUSE_MCHK;
        else
            cause_nxt = CAUSE_DEC;
    end
end

// state registers stay on pclk and keep updating while functional clocks are gated
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_r <= ST_FULL;
        cnt_r <= 4'h0;
        bus_cnt_r <= 4'h0;
        cause_r <= CAUSE_NONE;
        sleep_sel_r <= 1'b0;
    end
    else
    begin
        state_r <= state_nxt;
        cnt_r <= cnt_nxt;
        bus_cnt_r <= bus_cnt_nxt;
        cause_r <= cause_nxt;
        sleep_sel_r <= sleep_sel_nxt;
    end
end

// =====================================================================
// software registers
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        hwcfg_r <= RST_HW[`NSPS_HW_SLEEP:`NSPS_HW_DOZE];
        pow_r <= RST_MSR[`NSPS_MSR_POW];
        ee_r <= RST_MSR[`NSPS_MSR_EE];
        l2e_r <= RST_L2[`NSPS_L2_ENABLE];
        sram_ctl_r <= RST_L2[`NSPS_L2_SRAM_SLEEP];
    end
    else
    begin
        if (wr_en && paddr == `NSPS_OFS_HWCFG)
        begin
            hwcfg_r <= pwdata[`NSPS_HW_SLEEP:`NSPS_HW_DOZE];
        end
        if (wr_en && paddr == `NSPS_OFS_MSR)
        begin
            ee_r <= pwdata[`NSPS_MSR_EE];
        end
        // power enable clears on wake; a software write in the same cycle wins
        if (wr_en && paddr == `NSPS_OFS_MSR)
        begin
            pow_r <= pwdata[`NSPS_MSR_POW];
        end
        else if (state_r == ST_WAKE || (state_r == ST_FULL && pow_r && !invoke))
        begin
            pow_r <= 1'b0;
        end
        if (wr_en && paddr == `NSPS_OFS_L2CTL)
        begin
            l2e_r <= pwdata[`NSPS_L2_ENABLE];
            sram_ctl_r <= pwdata[`NSPS_L2_SRAM_SLEEP];
        end
    end
end

// read data captured in the setup phase
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata <= 32'h00000000;
    end
    else if (psel && !penable && !pwrite)
    begin
        case (paddr)
            `NSPS_OFS_HWCFG: prdata <= {21'h000000, hwcfg_r, 8'h00};
            `NSPS_OFS_MSR: prdata <= {30'h00000000, ee_r, pow_r};
            `NSPS_OFS_L2CTL: prdata <= {30'h00000000, sram_ctl_r, l2e_r};
            `NSPS_OFS_STATUS: prdata <= {12'h000, bus_cnt_r, 5'h00, cause_r, 2'h0, snoop_en,
                ~quiesce_request_n, state_r};
            default: prdata <= 32'h00000000;
        endcase
    end
end

// =====================================================================
// power domain outputs, registered from the next state; pll, dll and l2 clock enables from the bypass pin and l2 enable only
wire nx_nap = (state_nxt == ST_NAP);
wire nx_snp = (state_nxt == ST_NAPSNOOP);
wire nx_slp = (state_nxt == ST_SLEEP);
wire nx_run = (state_nxt == ST_FULL) | (state_nxt == ST_BUSWAIT) | (state_nxt == ST_QUIESCE_REQUEST) |
    (state_nxt == ST_WAKE);
wire nx_pll = ~bypass;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        quiesce_request_n <= 1'b1;
        units_clk_en <= 1'b1;
        snoop_en <= 1'b1;
        timebase_en <= 1'b1;
        thermal_en <= 1'b1;
        receivers_en <= 1'b1;
        sram_sleep_out <= 1'b0;
        pll_run <= 1'b1;
        dll_en <= 1'b0;
        l2_clock_out_a_en <= 1'b0;
        l2_clock_out_b_en <= 1'b0;
    end
    else
    begin
        quiesce_request_n <= ~((state_nxt == ST_QUIESCE_REQUEST) | (state_nxt == ST_ENTER) | nx_nap | nx_snp | nx_slp);
        units_clk_en <= nx_run;
        snoop_en <= nx_run | nx_snp;
        timebase_en <= ~nx_slp;
        thermal_en <= ~nx_slp;
        receivers_en <= nx_run | nx_snp | (state_nxt == ST_ENTER);
        sram_sleep_out <= sram_ctl_r & (nx_nap | nx_slp);
        pll_run <= nx_pll;
        dll_en <= l2e_r & nx_pll;
        l2_clock_out_a_en <= l2e_r & nx_pll;
        l2_clock_out_b_en <= l2e_r & nx_pll;
    end
end

endmodule

// file: verification/nsps_seq_asserts.sv
// port assertions for the nap and sleep sequencer
// assumes one pclk domain with asynchronous active-low presetn
`timescale 1ns/100ps
module nsps_seq_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // inputs watched
    input wire logic quiesce_acknowledge_n,
    input wire logic bus_idle,
    input wire logic pll_bypass,
    // outputs watched
    input wire logic quiesce_request_n,
    input wire logic units_clk_en,
    input wire logic snoop_en,
    input wire logic timebase_en,
    input wire logic receivers_en,
    input wire logic sram_sleep_out,
    input wire logic pll_run,
    input wire logic dll_en,
    input wire logic l2_clock_out_a_en,
    input wire logic l2_clock_out_b_en
);
    // ==========================================
    // handshake and power domain relations
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_acked_low;
        (!quiesce_acknowledge_n && !units_clk_en) [*8];
    endsequence
    sequence s_bypass_held;
        $stable(pll_bypass) [*8];
    endsequence
    a_quiesce_request_low_power: assert property (!units_clk_en |-> !quiesce_request_n)
        else $error("units stopped without quiesce request");
    a_quiesce_request_first: assert property ($fell(units_clk_en) |-> !$past(quiesce_request_n))
        else $error("entry without prior quiesce request");
    a_bus_idle_entry: assert property ($fell(quiesce_request_n) |-> $past(bus_idle))
        else $error("quiesce request while bus busy");
    a_wake_restores: assert property ($rose(quiesce_request_n) |-> units_clk_en && snoop_en)
        else $error("wake without units and snooping");
    a_sleep_all_off: assert property (!timebase_en |-> !snoop_en && !units_clk_en && !receivers_en)
        else $error("sleep left a unit running");
    a_sram_low_only: assert property (sram_sleep_out |-> !units_clk_en && !snoop_en && !quiesce_request_n)
        else $error("sram sleep outside low power");
    a_snoop_window: assert property ($rose(snoop_en) && !units_clk_en |-> $past(quiesce_acknowledge_n, 8))
        else $error("snoop opened too early");
    a_snoop_closes: assert property (s_acked_low |-> !snoop_en)
        else $error("snoop left on after acknowledge");
    a_pll_follow: assert property (s_bypass_held |-> pll_run == !pll_bypass)
        else $error("pll run does not follow bypass");
    a_dll_clocks: assert property (l2_clock_out_a_en == dll_en && l2_clock_out_b_en == dll_en)
        else $error("l2 clocks differ from dll enable");
endmodule

bind nsps_seq nsps_seq_asserts u_chk (.pclk, .presetn, .quiesce_acknowledge_n, .bus_idle, .pll_bypass,
    .quiesce_request_n, .units_clk_en, .snoop_en, .timebase_en, .receivers_en, .sram_sleep_out, .pll_run,
    .dll_en, .l2_clock_out_a_en, .l2_clock_out_b_en);

// file: verification/nsps_sys_model.sv
// system logic model answering the quiesce handshake
// assumes the acknowledge line is pulled up when released
`timescale 1ns/100ps
module nsps_sys_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // handshake
    input wire logic quiesce_request_n,
    output logic quiesce_acknowledge_n,
    // bench controls
    input wire logic snoop_req,
    input wire logic [7:0] ack_delay
);
    logic [7:0] cnt_r;
    // ==========================================
    // acknowledge after a programmable delay
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 8'h00;
            quiesce_acknowledge_n <= 1'b1;
        end
        else if (quiesce_request_n || snoop_req)
        begin
            cnt_r <= 8'h00;
            quiesce_acknowledge_n <= 1'b1;
        end
        else if (cnt_r < ack_delay)
            cnt_r <= cnt_r + 8'h01;
        else
            quiesce_acknowledge_n <= 1'b0;
    end
endmodule

// file: verification/nap_sleep_power_sequencer_tb.sv
// self-checking bench for the nap and sleep sequencer
// assumes zero wait state apb and the system model on the handshake
`timescale 1ns/100ps
`include "nsps_map.vh"
module nap_sleep_power_sequencer_tb;
    localparam logic [11:0] r_hw = `NSPS_OFS_HWCFG;
    localparam logic [11:0] r_msr = `NSPS_OFS_MSR;
    localparam logic [11:0] r_l2 = `NSPS_OFS_L2CTL;
    localparam logic [11:0] r_st = `NSPS_OFS_STATUS;
    localparam logic [31:0] m_all = 32'hFFFFFFFF;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, seed = 32'hA96DF523, bseed = 32'hA96DF523, q, prdata;
    logic ext_interrupt_n = 1'b1, system_mgmt_interrupt_in_n = 1'b1, machine_check_in_n = 1'b1;
    logic soft_reset_n = 1'b1, machine_check_event = 1'b0, decrementer_event = 1'b0, bus_idle = 1'b1;
    logic bus_clk_en = 1'b0, pll_bypass = 1'b0, snoop_req = 1'b0, e, pready, pslverr;
    logic [7:0] ack_delay = 8'h02;
    logic quiesce_acknowledge_n, quiesce_request_n, units_clk_en, snoop_en, timebase_en, thermal_en;
    logic receivers_en, sram_sleep_out, pll_run, dll_en, l2_clock_out_a_en, l2_clock_out_b_en;
    int err_total = 0;
    int n_compared = 0;
    int k;
    nsps_seq u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .quiesce_acknowledge_n, .quiesce_request_n, .ext_interrupt_n, .system_mgmt_interrupt_in_n,
        .machine_check_in_n, .soft_reset_n, .machine_check_event, .decrementer_event, .bus_idle,
        .bus_clk_en, .pll_bypass, .units_clk_en, .snoop_en, .timebase_en, .thermal_en, .receivers_en,
        .sram_sleep_out, .pll_run, .dll_en, .l2_clock_out_a_en, .l2_clock_out_b_en);
    nsps_sys_model u_sys (.pclk, .presetn, .quiesce_request_n, .quiesce_acknowledge_n, .snoop_req, .ack_delay);
    // ==========================================
    // clock, random bus clock, helpers
    initial
    begin
        forever #2 pclk = ~pclk;
    end
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] exp_st(input logic [3:0] s, input logic [2:0] c);
        return {21'h000000, c, 4'h0, s};
    endfunction
    always @(posedge pclk)
    begin
        bseed <= nxt(bseed);
        bus_clk_en <= bseed[0];
    end
    task automatic print_verdict;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_total);
            if (err_total == 0 && n_compared > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        begin
            n_compared++;
            if (got !== ex)
            begin
                err_total++;
                $display("ERROR %s expected %h seen %h", nm, ex, got);
            end
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do
            begin
                @(posedge pclk);
                n++;
            end
            while (pready !== 1'b1 && n < 20);
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
            if (n >= 20)
            begin
                err_total++;
                print_verdict;
            end
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] ex);
        begin
            apb(1'b0, a, 32'h00000000);
            chk("prdata", ex, q & m);
        end
    endtask
    task automatic wt(input logic sel, input logic v, input int lim);
        int n;
        begin
            n = 0;
            while ((sel ? snoop_en : units_clk_en) !== v && n < lim)
            begin
                @(posedge pclk);
                n++;
            end
            if (n >= lim)
            begin
                err_total++;
                print_verdict;
            end
        end
    endtask
    task automatic src(input int s);
        begin
            ext_interrupt_n <= (s != 0);
            system_mgmt_interrupt_in_n <= (s != 1);
            machine_check_in_n <= (s != 2);
            machine_check_event <= (s == 3);
            decrementer_event <= (s == 4);
            soft_reset_n <= (s != 5);
        end
    endtask
    task automatic go(input logic [31:0] mode);
        begin
            seed = nxt(seed);
            ack_delay <= {4'h0, seed[3:0]};
            apb(1'b1, r_hw, mode);
            apb(1'b1, r_msr, 32'h00000003);
            wt(1'b0, 1'b0, 100);
            repeat (6) @(posedge pclk);
            chk("quiesce_request", 32'h00000000, quiesce_request_n);
        end
    endtask
    // ==========================================
    // scenarios
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(r_hw, m_all, `NSPS_RST_HWCFG);
        rd(r_msr, m_all, `NSPS_RST_MSR);
        rd(r_l2, m_all, `NSPS_RST_L2CTL);
        rd(12'h010, m_all, 32'h00000000);
        chk("pslverr", 32'h00000001, e);
        seed = nxt(seed);
        apb(1'b1, r_hw, seed);
        rd(r_hw, m_all, seed & `NSPS_HW_MASK);
        apb(1'b1, r_msr, seed & 32'hFFFFFFFE);
        rd(r_msr, m_all, seed & 32'h00000002);
        apb(1'b1, r_st, seed);
        rd(r_st, 32'h0000070F, exp_st(4'h0, 3'h0));
        for (k = 0; k < 8; k++)
        begin
            if (k != 2 && k != 4)
            begin
                apb(1'b1, r_hw, k << 8);
                apb(1'b1, r_msr, 32'h00000003);
                repeat (4) @(posedge pclk);
                chk("quiesce_request", 32'h00000001, quiesce_request_n);
                rd(r_msr, m_all, 32'h00000002);
            end
        end
        apb(1'b1, r_l2, 32'h00000003);
        bus_idle <= 1'b0;
        ack_delay <= 8'h28;
        apb(1'b1, r_hw, 32'h00000200);
        apb(1'b1, r_msr, 32'h00000003);
        repeat (8) @(posedge pclk);
        chk("quiesce_request", 32'h00000001, quiesce_request_n);
        bus_idle <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("quiesce_request", 32'h00000000, quiesce_request_n);
        chk("units", 32'h00000001, units_clk_en);
        wt(1'b0, 1'b0, 100);
        repeat (6) @(posedge pclk);
        chk("nap outputs", 32'h00000033, {timebase_en, thermal_en, receivers_en, snoop_en, dll_en, sram_sleep_out});
        presetn <= 1'b0;
        @(posedge pclk);
        chk("reset wake", 32'h00000003, {quiesce_request_n, units_clk_en});
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, r_l2, 32'h00000001);
        for (k = 0; k < 6; k++)
        begin
            go(32'h00000200);
            rd(r_st, 32'h0000000F, exp_st(4'h4, 3'h0));
            chk("sram", 32'h00000000, sram_sleep_out);
            src(k);
            wt(1'b0, 1'b1, 12);
            src(7);
            repeat (8) @(posedge pclk);
            rd(r_st, 32'h0000070F, exp_st(4'h0, k + 1));
        end
        go(32'h00000200);
        snoop_req <= 1'b1;
        wt(1'b1, 1'b1, 200);
        rd(r_st, 32'h0000000F, exp_st(4'h5, 3'h0));
        snoop_req <= 1'b0;
        wt(1'b1, 1'b0, 40);
        rd(r_st, 32'h0000000F, exp_st(4'h4, 3'h0));
        src(4);
        wt(1'b0, 1'b1, 12);
        src(7);
        repeat (8) @(posedge pclk);
        go(32'h00000400);
        chk("sleep outputs", 32'h00000000, {timebase_en, thermal_en, receivers_en, snoop_en});
        src(4);
        repeat (12) @(posedge pclk);
        chk("units", 32'h00000000, units_clk_en);
        src(1);
        wt(1'b0, 1'b1, 12);
        src(7);
        repeat (8) @(posedge pclk);
        rd(r_st, 32'h0000070F, exp_st(4'h0, 3'h2));
        pll_bypass <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("pll dll", 32'h00000000, {pll_run, dll_en, l2_clock_out_a_en});
        pll_bypass <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("pll dll", 32'h00000007, {pll_run, dll_en, l2_clock_out_b_en});
        apb(1'b1, r_l2, 32'h00000000);
        repeat (4) @(posedge pclk);
        chk("dll", 32'h00000000, dll_en);
        apb(1'b1, r_l2, 32'h00000001);
        repeat (4) @(posedge pclk);
        chk("dll", 32'h00000001, dll_en);
        print_verdict;
    end
endmodule
